// ==== hdl/scba_pkg.sv ====
/*
 * constants, register map and enumerations for the column burst access block.
 * assumes a wishbone register bus on the system clock and a command link
 * running on its own link clock.
 */
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package scba_pkg;

    // ------------------------------------------------------------------------
    // array and link widths
    // ------------------------------------------------------------------------
    localparam int COL_W    = 6;
    localparam int DQ_W     = 16;
    localparam int LANES    = 2;
    localparam int LANE_W   = 8;
    localparam int MEM_D    = 64;
    localparam int SCHED_AW = 5;
    localparam int SCHED_D  = 32;
    localparam int LAT_W    = 4;
    localparam int CNT_W    = 6;

    // ------------------------------------------------------------------------
    // burst lengths and command spacing
    // ------------------------------------------------------------------------
    localparam logic [3:0] BEATS_CHOP = 4'h4;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam int         COL_TO_COL_DELAY = 4;

    // ------------------------------------------------------------------------
    // register map, fields and reset values
    // ------------------------------------------------------------------------
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_LAT  = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int AL_LSB  = 0;
    localparam int CL_LSB  = 4;
    localparam int CWL_LSB = 8;
    localparam int ST_RD   = 0;
    localparam int ST_WR   = 1;
    localparam int ST_CHOP = 2;
    localparam int ST_FLT  = 3;
    localparam logic [1:0]       MODE_RST = 2'h0;
    localparam logic [LAT_W-1:0] AL_RST   = 4'h0;
    localparam logic [LAT_W-1:0] CL_RST   = 4'h6;
    localparam logic [LAT_W-1:0] CWL_RST  = 4'h5;

    // ------------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_RD  = 3'h2,
        CMD_WR  = 3'h3,
        CMD_PRE = 3'h4
    } scba_cmd_t;

    typedef enum logic [1:0] {
        BF_FIX8 = 2'h0,
        BF_OTF  = 2'h1,
        BF_CHOP = 2'h2,
        BF_RSVD = 2'h3
    } scba_bfield_t;

endpackage

// ==== hdl/scba_top.sv ====
/*
 * column burst engine: wishbone registers on CLK_SYS, command link, array
 * and read/write burst engines on LINK_CLK.
 * assumes configuration is changed only while the link is idle.
 */
module scba_top (
    // system clock and reset
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST_B,
    // wishbone slave
    input  wire logic [7:0]                  WB_ADR_I,
    input  wire logic [31:0]                 WB_DAT_I,
    input  wire logic [3:0]                  WB_SEL_I,
    input  wire logic                        WB_WE_I,
    input  wire logic                        WB_CYC_I,
    input  wire logic                        WB_STB_I,
    output logic      [31:0]                 WB_DAT_O,
    output logic                             WB_ACK_O,
    // link command side
    input  wire logic                        LINK_CLK,
    input  wire logic [2:0]                  CMD,
    input  wire logic [scba_pkg::COL_W-1:0]  COL_ADDR,
    input  wire logic                        BURST_SEL,
    input  wire logic                        AUTO_PRE,
    // link data side
    input  wire logic [scba_pkg::DQ_W-1:0]   DQ_IN,
    output logic      [scba_pkg::DQ_W-1:0]   DQ_OUT,
    output logic                             DQ_OE_B,
    input  wire logic [scba_pkg::LANES-1:0]  WR_MASK,
    input  wire logic                        DQS_IN,
    output logic                             DQS_OUT,
    output logic                             DQS_OE_B
);

    // ------------------------------------------------------------------------
    // wishbone register file
    // ------------------------------------------------------------------------
    logic [1:0]                 mode_r;
    logic [scba_pkg::LAT_W-1:0] al_r;
    logic [scba_pkg::LAT_W-1:0] cl_r;
    logic [scba_pkg::LAT_W-1:0] cwl_r;
    logic                       ack_r;
    logic [31:0]                dat_r;
    logic [3:0]                 stat_s1_r;
    logic [3:0]                 stat_s2_r;
    wire                        wb_req   = WB_CYC_I & WB_STB_I & ~ack_r;
    wire                        wb_wr    = wb_req & WB_WE_I;
    wire                        sel_mode = (WB_ADR_I == scba_pkg::REG_MODE);
    wire                        sel_lat  = (WB_ADR_I == scba_pkg::REG_LAT);
    wire                        sel_stat = (WB_ADR_I == scba_pkg::REG_STAT);
    wire [31:0] rd_mux = sel_mode ? {30'h0, mode_r} :
                         sel_lat  ? {20'h0, cwl_r, cl_r, al_r} :
                         sel_stat ? {28'h0, stat_s2_r} : 32'h0;

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // bus answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= wb_req;
            dat_r <= wb_req ? rd_mux : dat_r;
        end
    end

    // software writes of burst field and latencies, per byte lane
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            mode_r <= scba_pkg::MODE_RST;
            al_r   <= scba_pkg::AL_RST;
            cl_r   <= scba_pkg::CL_RST;
            cwl_r  <= scba_pkg::CWL_RST;
        end else begin
            if (wb_wr && sel_mode && WB_SEL_I[0]) begin
                mode_r <= WB_DAT_I[1:0];
            end
            if (wb_wr && sel_lat && WB_SEL_I[0]) begin
                al_r <= WB_DAT_I[scba_pkg::AL_LSB +: scba_pkg::LAT_W];
                cl_r <= WB_DAT_I[scba_pkg::CL_LSB +: scba_pkg::LAT_W];
            end
            if (wb_wr && sel_lat && WB_SEL_I[1]) begin
                cwl_r <= WB_DAT_I[scba_pkg::CWL_LSB +: scba_pkg::LAT_W];
            end
        end
    end

    // ------------------------------------------------------------------------
    // crossings between the domains
    // ------------------------------------------------------------------------
    logic       lrst_s1_r;
    logic       lrst_b_r;
    logic [13:0] cfg_s1_r;
    logic [13:0] cfg_s2_r;
    logic [3:0]  stat_l_r;

    // reset and quasi-static configuration into the link domain
    always_ff @(posedge LINK_CLK) begin
        lrst_s1_r <= RST_B;
        lrst_b_r  <= lrst_s1_r;
        cfg_s1_r  <= {mode_r, cwl_r, cl_r, al_r};
        cfg_s2_r  <= cfg_s1_r;
    end

    // link status levels back into the system domain
    always_ff @(posedge CLK_SYS) begin
        stat_s1_r <= stat_l_r;
        stat_s2_r <= stat_s1_r;
    end

    wire [1:0]                 l_mode = cfg_s2_r[13:12];
    wire [scba_pkg::LAT_W-1:0] l_cwl  = cfg_s2_r[11:8];
    wire [scba_pkg::LAT_W-1:0] l_cl   = cfg_s2_r[7:4];
    wire [scba_pkg::LAT_W-1:0] l_al   = cfg_s2_r[3:0];

    // ------------------------------------------------------------------------
    // command decode and latency
    // ------------------------------------------------------------------------
    wire [4:0] rl_raw = {1'b0, l_al} + {1'b0, l_cl};
    wire [4:0] wl_raw = {1'b0, l_al} + {1'b0, l_cwl};
    wire [4:0] rl     = (rl_raw == 5'h0) ? 5'h1 : rl_raw;
    wire [4:0] wl     = (wl_raw == 5'h0) ? 5'h1 : wl_raw;
    wire       is_rd  = (CMD == scba_pkg::CMD_RD);
    wire       is_wr  = (CMD == scba_pkg::CMD_WR);
    // burst select picks length only on the on-the-fly field; auto precharge
    // plays no part in the choice, and the select bit never joins the column
    wire       cmd_len8 = (l_mode == scba_pkg::BF_OTF)  ? BURST_SEL :
                          (l_mode == scba_pkg::BF_CHOP) ? 1'b0 : 1'b1;

    // ------------------------------------------------------------------------
    // burst start schedules: slot = now + latency
    // ------------------------------------------------------------------------
    localparam int SCBA_SW = scba_pkg::COL_W + 2;
    logic [SCBA_SW-1:0] rd_sched_r [scba_pkg::SCHED_D];
    logic [SCBA_SW-1:0] wr_sched_r [scba_pkg::SCHED_D];
    logic [scba_pkg::SCHED_AW-1:0] tick_r;
    wire [scba_pkg::SCHED_AW-1:0] rd_ins = tick_r + rl;
    wire [scba_pkg::SCHED_AW-1:0] wr_ins = tick_r + wl;
    wire [SCBA_SW-1:0] rd_slot = rd_sched_r[tick_r];
    wire [SCBA_SW-1:0] wr_slot = wr_sched_r[tick_r];
    wire rd_go   = rd_slot[SCBA_SW-1];
    wire wr_go   = wr_slot[SCBA_SW-1];
    wire rd_go_8 = rd_slot[SCBA_SW-2];
    wire wr_go_8 = wr_slot[SCBA_SW-2];

    // slot is cleared as it is consumed; a new entry lands at least one ahead
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_b_r) begin
            tick_r <= '0;
            for (int i = 0; i < scba_pkg::SCHED_D; i++) begin
                rd_sched_r[i] <= '0;
                wr_sched_r[i] <= '0;
            end
        end else begin
            tick_r <= tick_r + 5'h1;
            rd_sched_r[tick_r] <= '0;
            wr_sched_r[tick_r] <= '0;
            if (is_rd) begin
                rd_sched_r[rd_ins] <= {1'b1, cmd_len8, COL_ADDR};
            end
            if (is_wr) begin
                wr_sched_r[wr_ins] <= {1'b1, cmd_len8, COL_ADDR};
            end
        end
    end

    // ------------------------------------------------------------------------
    // beat address: eight beats wrap in the octet, four in the nibble
    // ------------------------------------------------------------------------
    function automatic logic [scba_pkg::COL_W-1:0] beat_addr(
        input logic [scba_pkg::COL_W-1:0] col,
        input logic [2:0]                 k,
        input logic                       len8
    );
        logic [2:0] lo8;
        logic [1:0] lo4;
        lo8 = col[2:0] + k;
        lo4 = col[1:0] + k[1:0];
        beat_addr = len8 ? {col[5:3], lo8} : {col[5:2], lo4};
    endfunction

    // ------------------------------------------------------------------------
    // array, read burst engine and write burst engine
    // ------------------------------------------------------------------------
    logic [scba_pkg::DQ_W-1:0]  mem_r [scba_pkg::MEM_D];
    logic [3:0]                 rd_left_r;
    logic [2:0]                 rd_idx_r;
    logic                       rd_len8_r;
    logic [scba_pkg::COL_W-1:0] rd_col_r;
    logic [scba_pkg::DQ_W-1:0]  dq_r;
    logic [3:0]                 wr_left_r;
    logic [2:0]                 wr_idx_r;
    logic                       wr_len8_r;
    logic [scba_pkg::COL_W-1:0] wr_col_r;
    logic                       fault_r;
    logic                       last_chop_r;
    wire  rd_drive = (rd_left_r != 4'h0);
    wire  wr_beat  = (wr_left_r != 4'h0);
    wire  rd_more  = (rd_left_r > 4'h1);
    wire [scba_pkg::COL_W-1:0] rd_next  = beat_addr(rd_col_r, rd_idx_r, rd_len8_r);
    wire [scba_pkg::COL_W-1:0] rd_first = rd_slot[scba_pkg::COL_W-1:0];
    wire [scba_pkg::COL_W-1:0] wr_addr  = beat_addr(wr_col_r, wr_idx_r, wr_len8_r);
    wire [scba_pkg::LANES-1:0] lane_we;

    assign DQ_OUT   = dq_r;
    assign DQ_OE_B  = ~rd_drive;
    assign DQS_OUT  = rd_drive;
    assign DQS_OE_B = ~rd_drive;

    // read engine: a new start always wins, so back-to-back bursts chain
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_b_r) begin
            rd_left_r <= 4'h0;
            rd_idx_r  <= 3'h0;
            rd_len8_r <= 1'b0;
            rd_col_r  <= '0;
            dq_r      <= '0;
        end else if (rd_go) begin
            rd_left_r <= rd_go_8 ? scba_pkg::BEATS_FULL : scba_pkg::BEATS_CHOP;
            rd_idx_r  <= 3'h1;
            rd_len8_r <= rd_go_8;
            rd_col_r  <= rd_first;
            dq_r      <= mem_r[rd_first];
        end else if (rd_drive) begin
            rd_left_r <= rd_left_r - 4'h1;
            rd_idx_r  <= rd_idx_r + 3'h1;
            dq_r      <= rd_more ? mem_r[rd_next] : dq_r;
        end
    end

    // write engine: runs its beat count out whatever the strobe does
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_b_r) begin
            wr_left_r <= 4'h0;
            wr_idx_r  <= 3'h0;
            wr_len8_r <= 1'b0;
            wr_col_r  <= '0;
        end else if (wr_go) begin
            wr_left_r <= wr_go_8 ? scba_pkg::BEATS_FULL : scba_pkg::BEATS_CHOP;
            wr_idx_r  <= 3'h0;
            wr_len8_r <= wr_go_8;
            wr_col_r  <= wr_slot[scba_pkg::COL_W-1:0];
        end else if (wr_beat) begin
            wr_left_r <= wr_left_r - 4'h1;
            wr_idx_r  <= wr_idx_r + 3'h1;
        end
    end

    // per-lane write enables; the mask only counts on write beats
    generate
        for (genvar g = 0; g < scba_pkg::LANES; g++) begin : g_lane
            assign lane_we[g] = wr_beat & ~WR_MASK[g];
        end
    endgenerate

    // array write by byte lane; one process owns the whole array
    always_ff @(posedge LINK_CLK) begin
        for (int i = 0; i < scba_pkg::LANES; i++) begin
            if (lane_we[i]) begin
                mem_r[wr_addr][i*scba_pkg::LANE_W +: scba_pkg::LANE_W] <=
                    DQ_IN[i*scba_pkg::LANE_W +: scba_pkg::LANE_W];
            end
        end
    end

    // status: sticky strobe fault, last burst kind, engine activity
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_b_r) begin
            fault_r     <= 1'b0;
            last_chop_r <= 1'b0;
            stat_l_r    <= 4'h0;
        end else begin
            fault_r     <= fault_r | (wr_beat & ~DQS_IN);
            last_chop_r <= rd_go ? ~rd_go_8 : wr_go ? ~wr_go_8 : last_chop_r;
            stat_l_r    <= {fault_r, last_chop_r, wr_beat, rd_drive};
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    logic [scba_pkg::CNT_W-1:0] rd_since_r;
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_b_r) begin
            rd_since_r <= 6'h3f;
        end else begin
            rd_since_r <= is_rd ? 6'h1 : (rd_since_r == 6'h3f) ? rd_since_r : rd_since_r + 6'h1;
        end
    end

    a_otf_select: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (is_rd && l_mode == scba_pkg::BF_OTF)
            |=> rd_sched_r[$past(rd_ins)][SCBA_SW-2] == $past(BURST_SEL))
        else $error("burst select not followed on read");
    a_autopre_same: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (is_wr && AUTO_PRE && l_mode == scba_pkg::BF_OTF)
            |=> wr_sched_r[$past(wr_ins)][SCBA_SW-2] == $past(BURST_SEL))
        else $error("auto precharge changed burst length");
    a_eight_fixed: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (rd_go && rd_go_8) |=> rd_drive [*8] ##1 (!rd_drive || $past(rd_go)))
        else $error("eight-beat read not eight beats");
    a_chop_fixed: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        ((is_rd || is_wr) && l_mode == scba_pkg::BF_CHOP) |-> !cmd_len8 ##1 $stable(l_mode) [*1])
        else $error("fixed chop gave eight beats");
    a_chop_four: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (wr_go && !wr_go_8) |=> wr_beat [*4] ##1 (!wr_beat || $past(wr_go)))
        else $error("chopped write not four beats");
    a_mask_hold: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (wr_beat && WR_MASK[0])
            |=> mem_r[$past(wr_addr)][7:0] == $past(mem_r[wr_addr][7:0]))
        else $error("masked lane was written");
    a_read_no_mask: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (rd_drive && !wr_beat) |-> (lane_we == 2'b00))
        else $error("array written during read burst");
    a_rd_latency: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (rd_since_r == {1'b0, rl} && $stable(cfg_s2_r)) |-> rd_go ##1 rd_drive)
        else $error("read data not at read latency");
    a_fault_flag: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (wr_beat && !DQS_IN) |=> fault_r ##2 stat_l_r[scba_pkg::ST_FLT])
        else $error("strobe fault not recorded");
    a_no_hang: assert property (@(posedge LINK_CLK) disable iff (!lrst_b_r)
        (wr_beat && !DQS_IN && !wr_go) |-> ##[1:8] !wr_beat or ##[1:8] wr_go)
        else $error("write engine hung after fault");

endmodule

// ==== tb/scba_ctrl_model.sv ====
/*
 * controller-side partner: drives link commands, write beats, mask and strobe level.
 * assumes the bench calls one task at a time, after the link has left reset.
 */
module scba_ctrl_model (
    // link clock
    input  wire logic       link_clk,
    // command lines
    output logic [2:0]      cmd,
    output logic [5:0]      col_addr,
    output logic            burst_sel,
    output logic            auto_pre,
    // write data lines
    output logic [15:0]     dq_in,
    output logic [1:0]      wr_mask,
    output logic            dqs_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // idle levels and command tasks
    // ------------------------------------------------------------------------
    initial begin
        cmd = 3'h0;
        col_addr = 6'h0;
        burst_sel = 1'b0;
        auto_pre = 1'b0;
        dq_in = 16'h0;
        wr_mask = 2'h0;
        dqs_in = 1'b0;
    end

    // one command for one cycle; returns at the edge that samples it
    task automatic issue(input logic [2:0] c, input logic [5:0] col, input logic bs,
                         input logic ap);
        @(posedge link_clk);
        cmd <= c;
        col_addr <= col;
        burst_sel <= bs;
        auto_pre <= ap;
        @(posedge link_clk);
        cmd <= 3'h0;
        col_addr <= ~col;
    endtask

    // write burst: beats follow the write latency, strobe level of each beat taken from ok
    task automatic wr(input logic [5:0] col, input logic bs, input logic ap, input int n,
                      input int wl, input logic [127:0] d, input logic [15:0] m,
                      input logic [7:0] ok);
        issue(3'h3, col, bs, ap);
        repeat (wl) @(posedge link_clk);
        for (int k = 0; k < n; k++) begin
            dq_in <= d[16*k +: 16];
            wr_mask <= m[2*k +: 2];
            dqs_in <= ok[k];
            @(posedge link_clk);
        end
        dq_in <= ~d[16*(n-1) +: 16];
        dqs_in <= 1'b0;
        repeat (4) @(posedge link_clk);
    endtask

    // read: mask lines toggled meanwhile, next command no sooner than the burst
    task automatic rd(input logic [5:0] col, input logic bs, input logic ap, input int n,
                      input logic [1:0] junk);
        wr_mask <= junk;
        issue(3'h2, col, bs, ap);
        repeat (n - 2) @(posedge link_clk);
    endtask

    // precharge then reopen the row
    task automatic row_cycle(input int row_precharge_time);
        repeat (4) @(posedge link_clk);
        issue(3'h4, 6'h0, 1'b0, 1'b0);
        repeat (row_precharge_time) @(posedge link_clk);
        issue(3'h1, 6'h0, 1'b0, 1'b0);
    endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 * self-checking bench for the column burst engine.
 * assumes the partner model drives the link; queues carry expected results.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // signals, memory image, queues
    // ------------------------------------------------------------------------
    logic        CLK_SYS = 1'b0, RST_B = 1'b0, LINK_CLK = 1'b0;
    logic [7:0]  WB_ADR_I = 8'h0;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
    logic [3:0]  WB_SEL_I = 4'h0;
    logic        WB_WE_I = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_ACK_O;
    logic [2:0]  CMD;
    logic [5:0]  COL_ADDR;
    logic        BURST_SEL, AUTO_PRE, DQS_IN, DQS_OUT, DQ_OE_B, DQS_OE_B;
    logic [15:0] DQ_IN, DQ_OUT, mem [64], rq[$];
    logic [1:0]  WR_MASK;
    logic [31:0] wq[$];
    logic [15:0] rnd = 16'h005f;
    int          n_fail = 0, checks = 0;

    scba_top i_scba_top (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .WB_ADR_I(WB_ADR_I),
        .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .LINK_CLK(LINK_CLK),
        .CMD(CMD), .COL_ADDR(COL_ADDR), .BURST_SEL(BURST_SEL), .AUTO_PRE(AUTO_PRE),
        .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE_B(DQ_OE_B), .WR_MASK(WR_MASK),
        .DQS_IN(DQS_IN), .DQS_OUT(DQS_OUT), .DQS_OE_B(DQS_OE_B));
    scba_ctrl_model i_scba_ctrl_model (.link_clk(LINK_CLK), .cmd(CMD), .col_addr(COL_ADDR),
        .burst_sel(BURST_SEL), .auto_pre(AUTO_PRE), .dq_in(DQ_IN), .wr_mask(WR_MASK),
        .dqs_in(DQS_IN));

    // ------------------------------------------------------------------------
    // clocks, helpers, monitors
    // ------------------------------------------------------------------------
    initial forever #12.5 CLK_SYS = ~CLK_SYS;
    initial begin
        #4.1;
        forever #7.5 LINK_CLK = ~LINK_CLK;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // beat k of a burst: wraps inside its aligned group
    function automatic logic [5:0] loc(input logic [5:0] c, input int k, input logic l8);
        return l8 ? {c[5:3], c[2:0] + 3'(k)} : {c[5:2], c[1:0] + 2'(k)};
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic give_verdict;
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int t;
        @(posedge CLK_SYS);
        WB_ADR_I <= a;
        WB_WE_I <= we;
        WB_DAT_I <= d;
        WB_SEL_I <= 4'hf;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        t = 0;
        do begin
            @(posedge CLK_SYS);
            t++;
        end while (WB_ACK_O !== 1'b1 && t < 50);
        if (WB_ACK_O !== 1'b1) begin
            n_fail++;
            give_verdict();
        end
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
    endtask

    task automatic wbr(input logic [7:0] a, input logic [31:0] e);
        wq.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask

    // write burst with random data and optional random lane mask
    task automatic tw(input logic [5:0] c, input logic bs, input logic l8,
                      input logic [7:0] ok, input logic rm);
        logic [127:0] d;
        logic [15:0] m;
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            d[16*k +: 16] = rnd;
            m[2*k +: 2] = rm ? rnd[9:8] : 2'h0;
        end
        for (int k = 0; k < (l8 ? 8 : 4); k++) begin
            if (!m[2*k]) mem[loc(c, k, l8)][7:0] = d[16*k +: 8];
            if (!m[2*k+1]) mem[loc(c, k, l8)][15:8] = d[16*k+8 +: 8];
        end
        i_scba_ctrl_model.wr(c, bs, rnd[3], l8 ? 8 : 4, 6, d, m, ok);
    endtask

    task automatic tr(input logic [5:0] c, input logic bs, input logic l8);
        for (int k = 0; k < (l8 ? 8 : 4); k++) rq.push_back(mem[loc(c, k, l8)]);
        rnd = lfsr(rnd);
        i_scba_ctrl_model.rd(c, bs, rnd[0], l8 ? 8 : 4, rnd[2:1]);
    endtask

    task automatic drain;
        for (int t = 0; t < 100 && rq.size() > 0; t++) @(posedge LINK_CLK);
        repeat (8) @(posedge LINK_CLK);
    endtask

    // register answers compared at the acknowledging edge
    always @(posedge CLK_SYS) begin
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0)
            cmp("register", wq.size() ? wq.pop_front() : 'x, WB_DAT_O);
    end
    // every driven read beat must be owed, with the strobe high
    always @(posedge LINK_CLK) begin
        if (DQ_OE_B === 1'b0)
            cmp("read beat", {14'h0, 2'b01, rq.size() ? rq.pop_front() : 16'hx},
                {14'h0, DQS_OE_B, DQS_OUT, DQ_OUT});
    end

    initial begin
        repeat (20000) @(posedge CLK_SYS);
        n_fail++;
        give_verdict();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [5:0] c;
        logic bs, l8;
        repeat (2) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        wbr(scba_pkg::REG_MODE, 32'h0);
        wbr(scba_pkg::REG_LAT, 32'h0000_0560);
        wb(8'h0c, 1'b1, 32'hffff_ffff);
        wbr(8'h0c, 32'h0);
        wbr(scba_pkg::REG_STAT, 32'h0);
        wb(scba_pkg::REG_LAT, 1'b1, 32'h0000_0561);
        drain();
        for (int i = 0; i < 8; i++) tw(6'(8 * i), 1'b1, 1'b1, 8'hff, 1'b0);
        for (int md = 0; md < 4; md++) begin
            drain();
            wb(scba_pkg::REG_MODE, 1'b1, 32'(md));
            drain();
            for (int i = 0; i < 4; i++) begin
                rnd = lfsr(rnd);
                c = rnd[5:0];
                bs = rnd[6];
                l8 = md == 0 || md == 3 || (md == 1 && bs);
                tw(c, bs, l8, 8'hff, 1'b1);
                tr(c, bs, l8);
                tr(c ^ 6'h4, bs, l8);
            end
            i_scba_ctrl_model.row_cycle(4);
        end
        drain();
        wb(scba_pkg::REG_MODE, 1'b1, 32'h0);
        drain();
        tw(6'h20, 1'b0, 1'b1, 8'hfb, 1'b0);
        tr(6'h00, 1'b0, 1'b1);
        tr(6'h08, 1'b1, 1'b1);
        drain();
        repeat (8) @(posedge CLK_SYS);
        wbr(scba_pkg::REG_STAT, 32'h8);
        repeat (4) @(posedge CLK_SYS);
        cmp("pending results", 32'h0, 32'(rq.size() + wq.size()));
        give_verdict();
    end
endmodule
